/* File: pkg/boot_loader_map.vh */
// constants and layout for the serial eeprom boot loader
// Contract
// R1 - byte 9 bit 7 picks boot mode
// R2 - loader itself sets memory and clock config
// R3 - host mode loads only timing/memory config
// R4 - host mode reads only bytes 0..9
// R5 - autonomous: set bases, then copy program
// R6 - autonomous program up to nearly 2 KB
// R7 - eeprom reached only as i2c master
// R8 - eeprom answers device address 1010
// R9 - one eeprom, 128 bytes to 2 KB
// R10 - first byte read at reference clock/1000
// R11 - later bytes at fastest valid divider
// R12 - core and highway held until loader releases
// R13 - no other i2c master during load
// R14 - ascending fetch, done after last byte
`ifndef BOOT_LOADER_MAP_VH
`define BOOT_LOADER_MAP_VH
// i2c device select: 1010 pattern, block bits zero
`define EE_DEV_WR 8'hA0
`define EE_DEV_RD 8'hA1
`define EE_WORD0 8'h00
// engine commands
`define CMD_START 2'h0
`define CMD_WRITE 2'h1
`define CMD_READ 2'h2
`define CMD_STOP 2'h3
// serial clock divider and quarter-period counts
`define FIRST_DIV 1000
`define FIRST_QTR 10'h0FA
`define QTR_100K_100M 10'h0FA
`define QTR_100K_75M 10'h0BC
`define QTR_100K_50M 10'h07D
`define QTR_100K_33M 10'h053
`define QTR_400K_100M 10'h03F
`define QTR_400K_75M 10'h02F
`define QTR_400K_50M 10'h020
`define QTR_400K_33M 10'h015
// byte 0 field positions
`define B0_CLK_HI 3
`define B0_CLK_LO 2
`define B0_FAST 1
// eeprom layout
`define CFG_BYTES 10
`define MODE_IDX 11'h009
`define MODE_BIT 7
`define MEMBASE_IDX 11'h00A
`define MMIOBASE_IDX 11'h00E
`define LEN_HI_IDX 11'h012
`define LEN_LO_IDX 11'h013
`define PROG_IDX 11'h014
`define LAST_IDX 11'h7FF
`endif

/* File: rtl/i2c_byte_reader.v */
// i2c master byte engine: start, stop, byte write and byte read
`default_nettype none
`include "boot_loader_map.vh"
module i2c_byte_reader (
  input wire i_mclk,
  input wire i_rst_n,
  input wire [9:0] i_quarter,
  input wire i_cmd_valid,
  input wire [1:0] i_cmd,
  input wire [7:0] i_wdata,
  input wire i_last,
  input wire i_sda,
  output reg o_busy,
  output reg o_done,
  output reg [7:0] o_rdata,
  output reg o_nack,
  output reg o_scl_oe,
  output reg o_sda_oe
);
  reg [1:0] cmd;
  reg [1:0] q;
  reg [3:0] bitn;
  reg [9:0] tmr;
  reg [7:0] tx;
  reg scl_lvl;
  reg sda_lvl;
  wire qend = (tmr == i_quarter - 10'h001);

  // line levels per command, bit and quarter; only ever pull low, never drive high
  always @* begin
    scl_lvl = 1'b1;
    sda_lvl = 1'b1;
    case (cmd)
      `CMD_START: begin
        scl_lvl = (q != 2'h3);
        sda_lvl = (q < 2'h2);
      end
      `CMD_STOP: begin
        scl_lvl = (q != 2'h0);
        sda_lvl = (q >= 2'h2);
      end
      default: begin
        scl_lvl = (q == 2'h1) || (q == 2'h2);
        if (bitn < 4'h8)
          sda_lvl = (cmd == `CMD_WRITE) ? tx[7] : 1'b1;
        else
          sda_lvl = (cmd == `CMD_WRITE) ? 1'b1 : i_last; // ack unless last byte
      end
    endcase
  end

  // quarter-period sequencer; no clock stretching is honoured
  always @(posedge i_mclk) begin
    o_done <= 1'b0;
    if (!i_rst_n) begin
      o_busy <= 1'b0;
      o_rdata <= 8'h00;
      o_nack <= 1'b0;
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
      cmd <= `CMD_START;
      q <= 2'h0;
      bitn <= 4'h0;
      tmr <= 10'h000;
      tx <= 8'h00;
    end else if (!o_busy) begin
      if (i_cmd_valid) begin
        o_busy <= 1'b1;
        cmd <= i_cmd;
        tx <= i_wdata;
        q <= 2'h0;
        bitn <= 4'h0;
        tmr <= 10'h000;
      end
    end else begin
      o_scl_oe <= !scl_lvl;
      o_sda_oe <= !sda_lvl;
      tmr <= qend ? 10'h000 : tmr + 10'h001;
      if (qend) begin
        q <= q + 2'h1;
        if (q == 2'h1 && (cmd == `CMD_WRITE || cmd == `CMD_READ)) begin
          if (bitn < 4'h8)
            o_rdata <= {o_rdata[6:0], i_sda};
          else
            o_nack <= i_sda;
        end
        if (q == 2'h3) begin
          bitn <= bitn + 4'h1;
          tx <= {tx[6:0], 1'b1};
          if (cmd == `CMD_START || cmd == `CMD_STOP || bitn == 4'h8) begin
            o_busy <= 1'b0;
            o_done <= 1'b1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtl/serial_eeprom_boot_loader.v */
// boot loader: reads the boot eeprom over i2c, applies config, copies level 1 program
`default_nettype none
`include "boot_loader_map.vh"
module serial_eeprom_boot_loader (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_scl,
  input wire i_sda,
  input wire i_host_core_release,
  output reg o_scl_o,
  output reg o_scl_oe,
  output reg o_sda_o,
  output reg o_sda_oe,
  output reg [79:0] o_boot_cfg,
  output reg o_cfg_valid,
  output reg o_autonomous,
  output reg [31:0] o_main_memory_port_base,
  output reg [31:0] o_mmio_base,
  output reg o_mem_wr,
  output reg [31:0] o_mem_addr,
  output reg [7:0] o_mem_data,
  output reg o_core_rst_n,
  output reg o_highway_rst_n,
  output reg o_done,
  output reg o_error
);
  // boot sequencer states, in bus order
  localparam S_START = 4'h0;
  localparam S_DEVW = 4'h1;
  localparam S_ADDR = 4'h2;
  localparam S_RSTART = 4'h3;
  localparam S_DEVR = 4'h4;
  localparam S_READ = 4'h5;
  localparam S_STOP = 4'h6;
  localparam S_DONE = 4'h7;
  localparam S_FAIL = 4'h8;

  // sequencer bookkeeping and the command handshake towards the engine
  reg [3:0] state;
  reg pend;
  reg fail;
  reg cmd_valid;
  reg [1:0] cmd;
  reg [7:0] wdata;
  reg [9:0] quarter;
  reg [10:0] idx;
  reg [10:0] len;
  reg [9:0] next_quarter;
  reg last;
  // engine results
  wire eng_busy;
  wire eng_done;
  wire [7:0] eng_rdata;
  wire eng_nack;
  wire scl_oe;
  wire sda_oe;
  // offset of the current byte inside the level 1 program
  wire [10:0] prog_off = idx - `PROG_IDX;
  wire [10:0] len_live = {len[10:8], eng_rdata};

  // the engine is the only way to the eeprom; this block is the bus master [R7]
  i2c_byte_reader engine (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_quarter(quarter),
    .i_cmd_valid(cmd_valid),
    .i_cmd(cmd),
    .i_wdata(wdata),
    .i_last(last),
    .i_sda(i_sda),
    .o_busy(eng_busy),
    .o_done(eng_done),
    .o_rdata(eng_rdata),
    .o_nack(eng_nack),
    .o_scl_oe(scl_oe),
    .o_sda_oe(sda_oe)
  );

  // fastest valid divider from the decoded reference rate and eeprom grade [R11]
  always @* begin
    case ({eng_rdata[`B0_FAST], eng_rdata[`B0_CLK_HI:`B0_CLK_LO]})
      3'h0: next_quarter = `QTR_100K_100M;
      3'h1: next_quarter = `QTR_100K_75M;
      3'h2: next_quarter = `QTR_100K_50M;
      3'h3: next_quarter = `QTR_100K_33M;
      3'h4: next_quarter = `QTR_400K_100M;
      3'h5: next_quarter = `QTR_400K_75M;
      3'h6: next_quarter = `QTR_400K_50M;
      default: next_quarter = `QTR_400K_33M;
    endcase
  end

  // nack decision, sampled by the engine at the ack slot after the eighth bit
  always @* begin
    last = 1'b0;
    if (idx == `MODE_IDX && !eng_rdata[`MODE_BIT])
      last = 1'b1; // host mode: nothing past the ten config bytes [R4]
    else if (idx == `LEN_LO_IDX && len_live == 11'h000)
      last = 1'b1;
    else if (idx >= `PROG_IDX && prog_off + 11'h001 == len)
      last = 1'b1; // program finished [R5]
    else if (idx == `LAST_IDX)
      last = 1'b1; // 2 KB part ends here [R6] [R9]
  end

  // the lines are open drain: the output value is always low, enable pulls
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_scl_o <= 1'b0;
      o_sda_o <= 1'b0;
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      o_scl_oe <= scl_oe;
      o_sda_oe <= sda_oe;
    end
  end

  // boot sequencer: one random-address read at word 0, then sequential reads [R14]
  always @(posedge i_mclk) begin
    cmd_valid <= 1'b0;
    o_mem_wr <= 1'b0;
    if (!i_rst_n) begin
      state <= S_START;
      pend <= 1'b0;
      fail <= 1'b0;
      cmd <= `CMD_START;
      wdata <= 8'h00;
      quarter <= `FIRST_QTR; // reference clock / 1000 for the first byte [R10]
      idx <= 11'h000;
      len <= 11'h000;
      o_boot_cfg <= 80'h0;
      o_cfg_valid <= 1'b0;
      o_autonomous <= 1'b0;
      o_main_memory_port_base <= 32'h0;
      o_mmio_base <= 32'h0;
      o_mem_addr <= 32'h0;
      o_mem_data <= 8'h00;
      o_core_rst_n <= 1'b0; // core and highway stay in reset [R12]
      o_highway_rst_n <= 1'b0;
      o_done <= 1'b0;
      o_error <= 1'b0;
    end else begin
      // one command in flight at a time; pend covers the cycle before the engine shows busy
      if (!pend && !eng_busy && state < S_DONE) begin
        cmd_valid <= 1'b1;
        pend <= 1'b1;
        case (state)
          S_START: cmd <= `CMD_START;
          S_RSTART: cmd <= `CMD_START;
          S_DEVW: begin
            cmd <= `CMD_WRITE;
            wdata <= `EE_DEV_WR; // 1010 device select [R8]
          end
          S_ADDR: begin
            cmd <= `CMD_WRITE;
            wdata <= `EE_WORD0;
          end
          S_DEVR: begin
            cmd <= `CMD_WRITE;
            wdata <= `EE_DEV_RD;
          end
          S_READ: cmd <= `CMD_READ;
          default: cmd <= `CMD_STOP;
        endcase
      end
      if (eng_done) begin
        pend <= 1'b0;
        case (state)
          S_START: state <= S_DEVW;
          S_RSTART: state <= S_DEVR;
          S_DEVW, S_ADDR, S_DEVR: begin
            if (eng_nack) begin
              fail <= 1'b1; // nobody answered: give up, keep the core held
              state <= S_STOP;
            end else
              state <= (state == S_DEVW) ? S_ADDR : (state == S_ADDR) ? S_RSTART : S_READ;
          end
          S_READ: begin
            idx <= idx + 11'h001;
            if (idx == 11'h000)
              quarter <= next_quarter; // [R11]
            if (idx < `CFG_BYTES)
              o_boot_cfg <= {eng_rdata, o_boot_cfg[79:8]}; // [R2] [R3]
            if (idx == `MODE_IDX)
              o_autonomous <= eng_rdata[`MODE_BIT]; // [R1]
            // bases arrive most significant byte first
            if (idx >= `MEMBASE_IDX && idx < `MMIOBASE_IDX)
              o_main_memory_port_base <= {o_main_memory_port_base[23:0], eng_rdata}; // [R5]
            if (idx >= `MMIOBASE_IDX && idx < `LEN_HI_IDX)
              o_mmio_base <= {o_mmio_base[23:0], eng_rdata}; // [R5]
            // length is 11 bits: only the low three bits of the first length byte count
            if (idx == `LEN_HI_IDX)
              len <= {eng_rdata[2:0], 8'h00};
            if (idx == `LEN_LO_IDX)
              len <= len_live;
            if (idx >= `PROG_IDX) begin
              o_mem_wr <= 1'b1; // copy level 1 program into main memory [R5]
              o_mem_addr <= o_main_memory_port_base + {21'h0, prog_off};
              o_mem_data <= eng_rdata;
            end
            if (last)
              state <= S_STOP;
          end
          S_STOP: state <= fail ? S_FAIL : S_DONE;
          default: state <= state;
        endcase
      end
      // completion only once the last byte has been applied [R14]
      if (state == S_DONE) begin
        o_done <= 1'b1;
        o_cfg_valid <= 1'b1;
        o_highway_rst_n <= 1'b1; // [R12]
        if (o_autonomous || i_host_core_release)
          o_core_rst_n <= 1'b1; // host driver releases the core in host mode [R12]
      end
      // a missing part leaves every reset asserted; only the error flag shows it
      if (state == S_FAIL)
        o_error <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: sim/boot_loader_monitor.sv */
// checker on the boot loader top ports
`default_nettype none
module boot_loader_monitor (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_host_core_release,
  input wire logic o_scl_oe,
  input wire logic o_sda_oe,
  input wire logic o_cfg_valid,
  input wire logic o_autonomous,
  input wire logic o_mem_wr,
  input wire logic [31:0] o_mem_addr,
  input wire logic o_core_rst_n,
  input wire logic o_highway_rst_n,
  input wire logic o_done,
  input wire logic o_error
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  logic seen;
  logic [31:0] last;
  // keep the previous program address so order is judged across pulses
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) seen <= 1'b0;
    else if (o_mem_wr) seen <= 1'b1;
    if (o_mem_wr) last <= o_mem_addr;
  end
  property p_mem_auto; o_mem_wr |-> o_autonomous; endproperty
  a_mem_auto: assert property (p_mem_auto) else $error("program write in host mode");
  property p_mem_pulse; o_mem_wr |=> !o_mem_wr; endproperty
  a_mem_pulse: assert property (p_mem_pulse) else $error("write pulse too long");
  property p_mem_order; o_mem_wr && seen |-> o_mem_addr == last + 32'h1; endproperty
  a_mem_order: assert property (p_mem_order) else $error("program address out of order");
  property p_core_held; !o_done |-> !o_core_rst_n; endproperty
  a_core_held: assert property (p_core_held) else $error("core left reset early");
  property p_done_set; $rose(o_done) |-> o_highway_rst_n && o_cfg_valid; endproperty
  a_done_set: assert property (p_done_set) else $error("highway or valid late");
  property p_auto_core; $rose(o_done) && o_autonomous |-> o_core_rst_n; endproperty
  a_auto_core: assert property (p_auto_core) else $error("core not released");
  property p_host_core; o_done && !o_autonomous && i_host_core_release |-> ##[0:2] o_core_rst_n; endproperty
  a_host_core: assert property (p_host_core) else $error("host release ignored");
  property p_err; o_error |-> !o_done && !o_highway_rst_n; endproperty
  a_err: assert property (p_err) else $error("error with done");
  property p_idle; o_done |-> !o_scl_oe && !o_sda_oe; endproperty
  a_idle: assert property (p_idle) else $error("bus held after load");
endmodule
bind serial_eeprom_boot_loader boot_loader_monitor mon (.i_mclk, .i_rst_n, .i_host_core_release, .o_scl_oe,
  .o_sda_oe, .o_cfg_valid, .o_autonomous, .o_mem_wr, .o_mem_addr, .o_core_rst_n, .o_highway_rst_n, .o_done,
  .o_error);
`default_nettype wire

/* File: sim/boot_eeprom_model.sv */
// behavioural boot eeprom on the two-wire bus
`default_nettype none
module boot_eeprom_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic absent,
  output logic pull
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:2047];
  logic [7:0] sh;
  logic [10:0] ptr;
  logic rd = 0;
  int n = 0;
  int ph = 3;
  initial pull = 0;
  // start opens a frame, stop idles the part
  always @(negedge sda) if (scl) begin
    n = 0;
    ph = 0;
    rd = 0;
    pull = 0;
  end
  always @(posedge sda) if (scl) ph = 3;
  // shift in on the rising clock; a master nack ends the read
  always @(posedge scl) if (ph != 3) begin
    if (n < 8) sh = {sh[6:0], sda};
    if (n < 8) n = n + 1;
    else n = 0;
    if (n == 0 && rd && sda) ph = 3;
  end
  // change the line only while the clock is low so no false start is seen; the line is set once per edge, no glitch
  always @(negedge scl) begin
    logic nxt;
    nxt = 0;
    if (ph == 3) ;
    else if (rd) begin
      if (n < 8) nxt = !mem[ptr][7 - n];
      else ptr = ptr + 11'h001;
    end else if (n == 8) begin
      if (ph == 0 && sh[7:4] == 4'hA && !absent) begin
        nxt = 1;
        rd = sh[0];
        ph = 1;
      end else if (ph == 1) begin
        ptr = {3'h0, sh};
        nxt = 1;
        ph = 2;
      end else ph = 3;
    end
    pull = nxt;
  end
endmodule
`default_nettype wire

/* File: sim/tb_serial_eeprom_boot_loader.sv */
// testbench for the serial eeprom boot loader
`default_nettype none
module tb_serial_eeprom_boot_loader;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 0;
  logic i_rst_n = 0;
  logic i_host_core_release = 0;
  logic absent = 0;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int nw = 0;
  int p;
  logic [31:0] wa [0:3];
  logic [7:0] wd [0:3];
  wire logic pull, o_scl_o, o_scl_oe, o_sda_o, o_sda_oe, o_cfg_valid, o_autonomous, o_mem_wr;
  wire logic o_core_rst_n, o_highway_rst_n, o_done, o_error;
  wire logic [79:0] o_boot_cfg;
  wire logic [31:0] o_main_memory_port_base, o_mmio_base, o_mem_addr;
  wire logic [7:0] o_mem_data;
  // open-drain lines with pull-ups
  wire logic scl = !o_scl_oe;
  wire logic sda = !(o_sda_oe || pull);
  serial_eeprom_boot_loader dut (.i_mclk, .i_rst_n, .i_scl(scl), .i_sda(sda), .i_host_core_release, .o_scl_o,
    .o_scl_oe, .o_sda_o, .o_sda_oe, .o_boot_cfg, .o_cfg_valid, .o_autonomous, .o_main_memory_port_base,
    .o_mmio_base, .o_mem_wr, .o_mem_addr, .o_mem_data, .o_core_rst_n, .o_highway_rst_n, .o_done, .o_error);
  // the only other party on the bus, never a second master
  boot_eeprom_model ee (.scl(scl), .sda(sda), .absent(absent), .pull(pull));
  always #4 i_mclk = !i_mclk;
  // cut a hang short; the three loads need about 111k cycles, most of it the slow first byte
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 120000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // program write log, cleared by every reset so only this process drives the count
  always @(posedge i_mclk) begin
    if (!i_rst_n)
      nw <= 0;
    else if (o_mem_wr && nw < 4) begin
      wa[nw] <= o_mem_addr;
      wd[nw] <= o_mem_data;
      nw <= nw + 1;
    end
  end
  task check(input string what, input logic [79:0] seen, input logic [79:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, seen);
      n_mismatch++;
    end
  endtask
  task restart(input logic [7:0] b9, input logic gone);
    for (int i = 0; i < 2048; i++) ee.mem[i] = i[7:0] ^ 8'h5A;
    ee.mem[0] = 8'h0E; // 33 MHz code, fast grade: quarter of 21
    ee.mem[9] = b9;
    absent = gone;
    @(posedge i_mclk) i_rst_n <= 1'b0;
    i_host_core_release <= 1'b0;
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'b1;
  endtask
  task wait_done;
    for (int k = 0; k < 60000 && o_done !== 1'b1 && o_error !== 1'b1; k++) @(posedge i_mclk);
    check("load finished", o_done === 1'b1 || o_error === 1'b1, 1);
    repeat (2) @(posedge i_mclk);
  endtask
  task measure(output int per);
    @(posedge scl);
    per = 0;
    while (scl) begin @(posedge i_mclk); per++; end
    while (!scl) begin @(posedge i_mclk); per++; end
  endtask
  task t_host;
    logic [79:0] e;
    restart(8'h05, 1'b0);
    for (int i = 9; i >= 0; i--) e = {e[71:0], ee.mem[i]};
    measure(p);
    check("first scl period", p >= 999 && p <= 1001, 1);
    wait_done();
    check("config bytes", o_boot_cfg, e);
    check("autonomous", o_autonomous, 0);
    check("bytes fetched", ee.ptr, 10);
    check("program writes", nw, 0);
    check("valid", o_cfg_valid, 1);
    check("highway", o_highway_rst_n, 1);
    check("core held", o_core_rst_n, 0);
    check("open drain value", {o_scl_o, o_sda_o}, 2'h0);
    @(posedge i_mclk) i_host_core_release <= 1'b1;
    repeat (4) @(posedge i_mclk);
    check("core released", o_core_rst_n, 1);
    $display("host mode test ended");
  endtask
  task t_auto;
    restart(8'h85, 1'b0);
    {ee.mem[10], ee.mem[11], ee.mem[12], ee.mem[13]} = 32'h12345678;
    {ee.mem[14], ee.mem[15], ee.mem[16], ee.mem[17]} = 32'h9ABCDEF0;
    {ee.mem[18], ee.mem[19]} = 16'h0003;
    for (int k = 0; k < 60000 && nw == 0; k++) @(posedge i_mclk);
    measure(p);
    check("later scl period", p >= 83 && p <= 90, 1);
    wait_done();
    check("memory base", o_main_memory_port_base, 32'h12345678);
    check("mmio base", o_mmio_base, 32'h9ABCDEF0);
    check("writes", nw, 3);
    for (int i = 0; i < 3; i++) begin
      check("write addr", wa[i], 32'h12345678 + i);
      check("write data", wd[i], ee.mem[20 + i]);
    end
    check("bytes fetched", ee.ptr, 23);
    check("autonomous", o_autonomous, 1);
    check("core released", o_core_rst_n, 1);
    $display("autonomous test ended");
  endtask
  task t_absent;
    restart(8'h85, 1'b1);
    wait_done();
    check("error", o_error, 1);
    check("done", o_done, 0);
    check("highway held", o_highway_rst_n, 0);
    check("core held", o_core_rst_n, 0);
    $display("missing part test ended");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    t_host();
    t_auto();
    t_absent();
    tally_and_finish();
  end
endmodule
`default_nettype wire
